/* File: pkg/pwr_wake_pkg.sv */
// Package: register map, field layout, reset values and timing constants
// for the network adapter power-state and wake controller.
// Assumes AXI4-Lite with 32-bit data, one aligned word per register.
package pwr_wake_pkg;

  // Device power states, one-hot
  typedef enum logic [3:0] {
    PS_D0 = 4'h1,
    PS_D1 = 4'h2,
    PS_D2 = 4'h4,
    PS_D3 = 4'h8
  } pstate_t;

  // Encoded power-state request field (software view)
  localparam logic [1:0] REQ_D0 = 2'h0;
  localparam logic [1:0] REQ_D1 = 2'h1;
  localparam logic [1:0] REQ_D2 = 2'h2;
  localparam logic [1:0] REQ_D3 = 2'h3;

  // Register byte offsets
  localparam logic [7:0] OFF_PSCTL = 8'h00;
  localparam logic [7:0] OFF_PSSTAT = 8'h04;
  localparam logic [7:0] OFF_WAKECFG = 8'h08;
  localparam logic [7:0] OFF_IRQSTAT = 8'h0C;
  localparam logic [7:0] OFF_IRQMASK = 8'h10;
  localparam logic [7:0] OFF_STAID_LO = 8'h14;
  localparam logic [7:0] OFF_STAID_HI = 8'h18;
  localparam logic [7:0] OFF_PATTERN = 8'h1C;

  // Wake configuration bits
  localparam int WC_PME_EN = 0;
  localparam int WC_LINK_EN = 1;
  localparam int WC_WAKEPKT_EN = 2;
  localparam int WC_MGMT_EN = 3;
  localparam int WC_UCAST_EN = 4;

  // Interrupt / wake status bits
  localparam int EV_LINK_UP = 0;
  localparam int EV_LINK_DOWN = 1;
  localparam int EV_WAKE_FRAME = 2;
  localparam int EV_WAKE = 3;
  localparam int EV_PS_CHANGE = 4;
  localparam int EV_W = 5;

  // Frame classes reported by the receive filter
  localparam int FC_WAKEPKT = 0;
  localparam int FC_MGMT = 1;
  localparam int FC_UCAST = 2;

  // Reset values
  localparam logic [4:0] WAKECFG_RST = 5'h00;
  localparam logic [EV_W-1:0] IRQMASK_RST = 5'h00;
  localparam logic [1:0] CAPS_RST = 2'h3;

  // Link debounce: 10 ms settle time at 50 ns clock
  localparam int CLK_NS = 50;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_US * 1000) / CLK_NS;

endpackage

/* File: hdl/link_debounce.sv */
// Link status debouncer: two-flop synchroniser followed by a settle counter.
// Assumes link_raw is asynchronous to mclk.
`timescale 1ns/1ps
module link_debounce #(
  parameter int SETTLE_CYC = pwr_wake_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Raw link level
  input wire logic link_raw,
  // Debounced level and edge pulses
  output logic link_q,
  output logic rise_q,
  output logic fall_q
);
  localparam int CW = $clog2(SETTLE_CYC + 1);
  logic meta_q;
  logic sync_q;
  logic [CW-1:0] cnt_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= link_raw;
      sync_q <= meta_q;
    end
  end

  // Level must hold for the settle time before it is accepted
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      link_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if (sync_q == link_q) begin
        cnt_q <= '0;
      end else if (cnt_q == CW'(SETTLE_CYC - 1)) begin
        cnt_q <= '0;
        link_q <= sync_q;
        rise_q <= sync_q;
        fall_q <= ~sync_q;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end
endmodule // link_debounce

/* File: hdl/axil_slave.sv */
// AXI4-Lite slave front end: one write and one read at a time.
// Turns bus traffic into single-cycle write and read strobes.
`timescale 1ns/1ps
module axil_slave (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // Write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read address and data
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register-file side
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  assign awready = ~aw_have_q & ~bvalid;
  assign wready = ~w_have_q & ~bvalid;
  assign wr_en = aw_have_q & w_have_q & ~bvalid;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_err ? 2'h2 : 2'h0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  assign arready = ~rvalid;
  assign rd_en = arvalid & arready;
  assign rd_addr = araddr;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else if (rd_en) begin
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_err ? 2'h2 : 2'h0;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule // axil_slave

/* File: hdl/net_pwr_wake.sv */
// Power-state and wake controller for a network adapter function.
// Assumes the host orders state changes over AXI4-Lite, link_raw is an
// asynchronous pin, and the receive filter runs on mclk.
`timescale 1ns/1ps
module net_pwr_wake #(
  parameter int SETTLE_CYC = pwr_wake_pkg::DEBOUNCE_CYC,
  parameter bit HAS_D1 = 1'b1,
  parameter bit HAS_D2 = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // AXI4-Lite register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Host transmit request path
  input wire logic tx_req_valid,
  output logic tx_req_ready,
  output logic tx_req_go,
  // Receive-to-memory path
  input wire logic rx_valid,
  output logic rx_ready,
  output logic rx_to_mem,
  // Received frame summary from the MAC
  input wire logic frame_done,
  input wire logic [47:0] frame_dest,
  input wire logic frame_wakepkt,
  input wire logic frame_mgmt,
  input wire logic [31:0] frame_pattern,
  // Function interrupts and outputs to system
  input wire logic func_irq,
  output logic irq,
  output logic wake_out,
  output logic [1:0] pstate_out,
  // Network link status pin
  input wire logic link_raw
);
  pwr_wake_pkg::pstate_t ps_q;
  logic low_pwr;
  logic wr_en;
  logic rd_en;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_data;
  logic wr_err;
  logic rd_err;
  logic [4:0] wakecfg_q;
  logic [pwr_wake_pkg::EV_W-1:0] stat_q;
  logic [pwr_wake_pkg::EV_W-1:0] mask_q;
  logic [pwr_wake_pkg::EV_W-1:0] ev_set;
  logic [47:0] staid_q;
  logic [31:0] pattern_q;
  logic link_q;
  logic link_rise;
  logic link_fall;
  logic [2:0] fclass;
  logic frame_hit;
  logic wr_ps;
  logic [1:0] req_ps;
  logic ps_ok;
  logic [1:0] ps_code;

  axil_slave u_bus (
    .mclk(mclk), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_strb(wr_strb), .wr_err(wr_err),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_err(rd_err)
  );

  link_debounce #(.SETTLE_CYC(SETTLE_CYC)) u_link (
    .mclk(mclk), .rst_n(rst_n), .link_raw(link_raw),
    .link_q(link_q), .rise_q(link_rise), .fall_q(link_fall)
  );

  // Power-state request; unsupported optional states are refused
  assign wr_ps = wr_en && wr_addr == pwr_wake_pkg::OFF_PSCTL && wr_strb[0];
  assign req_ps = wr_data[1:0];
  always_comb begin
    ps_ok = 1'b1;
    if (req_ps == pwr_wake_pkg::REQ_D1) begin
      ps_ok = HAS_D1;
    end else if (req_ps == pwr_wake_pkg::REQ_D2) begin
      ps_ok = HAS_D2;
    end
  end

  // State follows host orders; policy choice is the host's
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ps_q <= pwr_wake_pkg::PS_D0;
    end else if (wr_ps && ps_ok) begin
      unique case (req_ps)
        pwr_wake_pkg::REQ_D0: ps_q <= pwr_wake_pkg::PS_D0;
        pwr_wake_pkg::REQ_D1: ps_q <= pwr_wake_pkg::PS_D1;
        pwr_wake_pkg::REQ_D2: ps_q <= pwr_wake_pkg::PS_D2;
        pwr_wake_pkg::REQ_D3: ps_q <= pwr_wake_pkg::PS_D3;
      endcase
    end
  end

  always_comb begin
    unique case (ps_q)
      pwr_wake_pkg::PS_D0: ps_code = pwr_wake_pkg::REQ_D0;
      pwr_wake_pkg::PS_D1: ps_code = pwr_wake_pkg::REQ_D1;
      pwr_wake_pkg::PS_D2: ps_code = pwr_wake_pkg::REQ_D2;
      default: ps_code = pwr_wake_pkg::REQ_D3;
    endcase
  end
  assign pstate_out = ps_code;
  assign low_pwr = ps_q != pwr_wake_pkg::PS_D0;

  // Data paths pass untouched in D0 and are cut otherwise
  assign tx_req_ready = ~low_pwr;
  assign tx_req_go = tx_req_valid & ~low_pwr;
  assign rx_ready = 1'b1;
  assign rx_to_mem = rx_valid & ~low_pwr;

  // Frame classification against preloaded identity
  assign fclass[pwr_wake_pkg::FC_WAKEPKT] = frame_wakepkt
    && frame_pattern == pattern_q
    && wakecfg_q[pwr_wake_pkg::WC_WAKEPKT_EN];
  assign fclass[pwr_wake_pkg::FC_MGMT] = frame_mgmt
    && wakecfg_q[pwr_wake_pkg::WC_MGMT_EN];
  assign fclass[pwr_wake_pkg::FC_UCAST] = frame_dest == staid_q
    && wakecfg_q[pwr_wake_pkg::WC_UCAST_EN];
  assign frame_hit = frame_done && low_pwr && |fclass;

  // Status events
  always_comb begin
    ev_set = '0;
    ev_set[pwr_wake_pkg::EV_LINK_UP] = link_rise;
    ev_set[pwr_wake_pkg::EV_LINK_DOWN] = link_fall;
    ev_set[pwr_wake_pkg::EV_WAKE_FRAME] = frame_hit;
    ev_set[pwr_wake_pkg::EV_WAKE] = wakecfg_q[pwr_wake_pkg::WC_PME_EN]
      && low_pwr && (frame_hit || (wakecfg_q[pwr_wake_pkg::WC_LINK_EN]
      && (link_rise || link_fall)));
    ev_set[pwr_wake_pkg::EV_PS_CHANGE] = wr_ps && ps_ok;
  end

  // Sticky status, write one to clear, set wins over clear
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stat_q <= '0;
    end else begin
      if (wr_en && wr_addr == pwr_wake_pkg::OFF_IRQSTAT && wr_strb[0]) begin
        stat_q <= (stat_q & ~wr_data[pwr_wake_pkg::EV_W-1:0]) | ev_set;
      end else begin
        stat_q <= stat_q | ev_set;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wakecfg_q <= pwr_wake_pkg::WAKECFG_RST;
      mask_q <= pwr_wake_pkg::IRQMASK_RST;
      staid_q <= '0;
      pattern_q <= '0;
    end else if (wr_en) begin
      unique case (wr_addr)
        pwr_wake_pkg::OFF_WAKECFG:
          if (wr_strb[0]) wakecfg_q <= wr_data[4:0];
        pwr_wake_pkg::OFF_IRQMASK:
          if (wr_strb[0]) mask_q <= wr_data[pwr_wake_pkg::EV_W-1:0];
        pwr_wake_pkg::OFF_STAID_LO: begin
          for (int i = 0; i < 4; i++) begin
            if (wr_strb[i]) staid_q[i*8 +: 8] <= wr_data[i*8 +: 8];
          end
        end
        pwr_wake_pkg::OFF_STAID_HI: begin
          if (wr_strb[0]) staid_q[39:32] <= wr_data[7:0];
          if (wr_strb[1]) staid_q[47:40] <= wr_data[15:8];
        end
        pwr_wake_pkg::OFF_PATTERN: begin
          for (int i = 0; i < 4; i++) begin
            if (wr_strb[i]) pattern_q[i*8 +: 8] <= wr_data[i*8 +: 8];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Wake held until software clears it; interrupts muted out of D0
  assign wake_out = stat_q[pwr_wake_pkg::EV_WAKE];
  assign irq = ~low_pwr && (|(stat_q & mask_q) || func_irq);

  // Write address check and read mux
  always_comb begin
    wr_err = 1'b0;
    unique case (wr_addr)
      pwr_wake_pkg::OFF_PSCTL, pwr_wake_pkg::OFF_WAKECFG,
      pwr_wake_pkg::OFF_IRQSTAT, pwr_wake_pkg::OFF_IRQMASK,
      pwr_wake_pkg::OFF_STAID_LO, pwr_wake_pkg::OFF_STAID_HI,
      pwr_wake_pkg::OFF_PATTERN: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (rd_addr)
      pwr_wake_pkg::OFF_PSCTL: rd_data[1:0] = ps_code;
      pwr_wake_pkg::OFF_PSSTAT: rd_data = {28'h0, HAS_D2, HAS_D1,
                                           link_q, low_pwr};
      pwr_wake_pkg::OFF_WAKECFG: rd_data[4:0] = wakecfg_q;
      pwr_wake_pkg::OFF_IRQSTAT: rd_data[pwr_wake_pkg::EV_W-1:0] = stat_q;
      pwr_wake_pkg::OFF_IRQMASK: rd_data[pwr_wake_pkg::EV_W-1:0] = mask_q;
      pwr_wake_pkg::OFF_STAID_LO: rd_data = staid_q[31:0];
      pwr_wake_pkg::OFF_STAID_HI: rd_data[15:0] = staid_q[47:32];
      pwr_wake_pkg::OFF_PATTERN: rd_data = pattern_q;
      default: rd_err = 1'b1;
    endcase
  end
endmodule // net_pwr_wake

/* File: tb/net_pwr_wake_chk.sv */
// Checker: traffic gating, interrupt gating and wake status timing.
// Assumes binding to the top module's ports, one clock domain.
`timescale 1ns/1ps
module net_pwr_wake_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Gated paths
  input wire logic tx_req_valid,
  input wire logic tx_req_ready,
  input wire logic tx_req_go,
  input wire logic rx_valid,
  input wire logic rx_to_mem,
  // Interrupt, wake, state, write response
  input wire logic func_irq,
  input wire logic irq,
  input wire logic wake_out,
  input wire logic [1:0] pstate_out,
  input wire logic bvalid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  tx_gate_a: assert property (
    tx_req_go == (tx_req_valid && pstate_out == 2'h0))
    else $error("transmit passed outside full power");
  rx_gate_a: assert property (
    rx_to_mem == (rx_valid && pstate_out == 2'h0))
    else $error("receive passed outside full power");
  tx_ready_a: assert property (
    tx_req_ready == (pstate_out == 2'h0))
    else $error("transmit ready wrong for state");
  irq_low_a: assert property (
    pstate_out != 2'h0 |-> !irq)
    else $error("interrupt in low power");
  irq_pass_a: assert property (
    pstate_out == 2'h0 && func_irq |-> irq)
    else $error("function interrupt lost");
  ps_write_a: assert property (
    $changed(pstate_out) |-> $rose(bvalid))
    else $error("state changed without a write");
  wake_set_a: assert property (
    $rose(wake_out) |-> $past(pstate_out) != 2'h0)
    else $error("wake raised in full power");
  wake_clr_a: assert property (
    $fell(wake_out) |-> $rose(bvalid))
    else $error("wake dropped without a write");
endmodule // net_pwr_wake_chk

bind net_pwr_wake net_pwr_wake_chk i_net_pwr_wake_chk (
  .mclk, .rst_n, .tx_req_valid, .tx_req_ready, .tx_req_go, .rx_valid,
  .rx_to_mem, .func_irq, .irq, .wake_out, .pstate_out, .bvalid
);

/* File: tb/host_axil.sv */
// Host model: AXI4-Lite master, one transfer per call.
// Assumes the slave answers in its own time; bench bounds the wait.
`timescale 1ns/1ps
module host_axil (
  // Clock
  input wire logic mclk,
  // Write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
  initial {araddr, arvalid, rready} = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        r = bresp;
      end
    end while (awvalid || wvalid || bready);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
      end
    end while (arvalid || rready);
  endtask
endmodule // host_axil

/* File: tb/tb_top.sv */
// Testbench: power states, gating, link and frame wake.
// Assumes the host model owns the bus; the bench drives the rest.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] PS = pwr_wake_pkg::OFF_PSCTL;
  localparam logic [7:0] WC = pwr_wake_pkg::OFF_WAKECFG;
  localparam logic [7:0] IS = pwr_wake_pkg::OFF_IRQSTAT;
  localparam logic [7:0] IM = pwr_wake_pkg::OFF_IRQMASK;
  localparam logic [47:0] STA = 48'h4567_89AB_CDEF;
  localparam logic [31:0] PAT = 32'h5A5A_A5A5;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rr, pstate_out;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic tx_req_ready, tx_req_go, rx_ready, rx_to_mem, irq, wake_out;
  logic tx_req_valid = 1'b0;
  logic rx_valid = 1'b0;
  logic frame_done = 1'b0;
  logic frame_wakepkt = 1'b0;
  logic frame_mgmt = 1'b0;
  logic func_irq = 1'b0;
  logic link_raw = 1'b0;
  logic [47:0] frame_dest = '0;
  logic [31:0] frame_pattern = '0;
  int n_fail = 0;
  int n_tests = 0;
  always #25 mclk = ~mclk;
  net_pwr_wake #(.SETTLE_CYC(4)) i_net_pwr_wake (
    .mclk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .tx_req_valid, .tx_req_ready,
    .tx_req_go, .rx_valid, .rx_ready, .rx_to_mem, .frame_done,
    .frame_dest, .frame_wakepkt, .frame_mgmt, .frame_pattern, .func_irq,
    .irq, .wake_out, .pstate_out, .link_raw
  );
  host_axil i_host_axil (
    .mclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready
  );
  task automatic chk(input string n, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    i_host_axil.wr(a, d, rr);
  endtask
  task automatic r(input logic [7:0] a);
    i_host_axil.rd(a, rv, rr);
  endtask
  task automatic complete_run();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_reset();
    r(PS);
    chk("psctl", 32'h0, rv);
    r(pwr_wake_pkg::OFF_PSSTAT);
    chk("psstat", 32'hC, rv);
    r(WC);
    chk("wakecfg", 32'h0, rv);
    r(8'h40);
    chk("unmapped", 32'h2, rr);
    w(8'h40, 32'h1);
    chk("wr_unmapped", 32'h2, rr);
    $display("t_reset done");
  endtask
  task automatic t_states();
    tx_req_valid <= 1'b1;
    rx_valid <= 1'b1;
    func_irq <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      w(PS, i);
      chk("bresp", 32'h0, rr);
      r(PS);
      chk("psctl", i, rv[1:0]);
      chk("pstate", i, pstate_out);
      chk("tx_go", i == 0, tx_req_go);
      chk("rx_mem", i == 0, rx_to_mem);
      chk("irq", i == 0, irq);
      chk("tx_rdy", i == 0, tx_req_ready);
      chk("rx_rdy", 1'b1, rx_ready);
      w(PS, 0);
      chk("tx_back", 1'b1, tx_req_go);
    end
    tx_req_valid <= 1'b0;
    rx_valid <= 1'b0;
    func_irq <= 1'b0;
    $display("t_states done");
  endtask
  task automatic t_link();
    w(IS, 32'h1F);
    w(WC, 32'h3);
    w(IM, 32'h1);
    link_raw <= 1'b1;
    repeat (2) @(posedge mclk);
    link_raw <= 1'b0;
    repeat (20) @(posedge mclk);
    r(IS);
    chk("glitch", 32'h0, rv[1:0]);
    link_raw <= 1'b1;
    repeat (20) @(posedge mclk);
    r(IS);
    chk("link_up", 32'h1, rv[1:0]);
    chk("irq_on", 1'b1, irq);
    w(IM, 32'h0);
    chk("irq_mask", 1'b0, irq);
    w(IS, 32'h1);
    r(IS);
    chk("w1c", 32'h0, rv[1:0]);
    w(PS, 3);
    link_raw <= 1'b0;
    repeat (20) @(posedge mclk);
    chk("wake", 1'b1, wake_out);
    w(IM, 32'h1F);
    chk("irq_d3", 1'b0, irq);
    w(PS, 0);
    chk("wake_hold", 1'b1, wake_out);
    r(IS);
    chk("link_down", 32'hA, rv[3:0]);
    w(IS, 32'h1F);
    chk("wake_clr", 1'b0, wake_out);
    w(IM, 32'h0);
    w(PS, 3);
    link_raw <= 1'b1;
    repeat (20) @(posedge mclk);
    chk("wake_up", 1'b1, wake_out);
    w(PS, 0);
    w(IS, 32'h1F);
    $display("t_link done");
  endtask
  task automatic fcase(input logic p, m, input logic [47:0] d,
                       input logic [31:0] pt, input logic e, ew);
    frame_done <= 1'b1;
    frame_wakepkt <= p;
    frame_mgmt <= m;
    frame_dest <= d;
    frame_pattern <= pt;
    @(posedge mclk);
    frame_done <= 1'b0;
    r(IS);
    chk("wake_frame", e, rv[2]);
    chk("wake_out", ew, wake_out);
    w(IS, 32'h1F);
  endtask
  task automatic t_frames();
    w(pwr_wake_pkg::OFF_STAID_LO, STA[31:0]);
    w(pwr_wake_pkg::OFF_STAID_HI, {16'h0, STA[47:32]});
    w(pwr_wake_pkg::OFF_PATTERN, PAT);
    w(WC, 32'h1D);
    w(PS, 1);
    fcase(1'b1, 1'b0, 48'h1, 32'h0, 1'b0, 1'b0);
    fcase(1'b1, 1'b0, 48'h1, PAT, 1'b1, 1'b1);
    fcase(1'b0, 1'b1, 48'h1, 32'h0, 1'b1, 1'b1);
    fcase(1'b0, 1'b0, STA, 32'h0, 1'b1, 1'b1);
    fcase(1'b0, 1'b0, 48'h1, 32'h0, 1'b0, 1'b0);
    w(WC, 32'h1C);
    fcase(1'b0, 1'b0, STA, 32'h0, 1'b1, 1'b0);
    w(PS, 0);
    fcase(1'b0, 1'b1, 48'h1, 32'h0, 1'b0, 1'b0);
    $display("t_frames done");
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_states();
    t_link();
    t_frames();
    complete_run();
  end
endmodule // tb_top
